// ### fast_charge_current_control.sv
// Fast-charge current control register behind a two-wire serial slave.
// Assumes scl and sda arrive asynchronously and sda is open drain.
`timescale 1ns/10ps
`default_nettype none
`include "fcc_params.svh"
module fast_charge_current_control
   import fcc_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = `FCC_DEV_ADDR
)
(
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   output logic [8:0] charge_current_ma_out,
   output logic external_current_select_out,
   output logic charger_disable_out,
   output logic high_impedance_out
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic scl_prev_reg;
   logic sda_prev_reg;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   serial_state_t state_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [7:0] pointer_reg;
   logic [2:0] bit_cnt_reg;
   logic byte_done_reg;
   logic rw_reg;
   logic nack_reg;
   logic wr_strobe;
   fast_charge_control_t control_reg;
   charge_setting_t setting_next;
   logic [7:0] read_data;

   // ---------------------------------------------------------------
   // Decode of the control byte
   // ---------------------------------------------------------------
   // Range and code to effective setting; the read path never sees this
   function automatic charge_setting_t decode_setting(
      input fast_charge_control_t ctl
   );
      charge_setting_t s;
      logic [8:0] raw;
      s.charger_disable = ctl.charger_disable;
      s.high_impedance = ctl.high_impedance;
      s.use_external = ctl.charge_current_code == `FCC_CODE_EXTERNAL;
      if (!ctl.charge_range_select)
      begin
         // Code bits weigh 16/8/4/2/1 mA
         raw = `FCC_LOW_BASE
             + 9'(ctl.charge_current_code) * `FCC_LOW_STEP;
         s.current_ma = (raw > `FCC_LOW_MAX) ? `FCC_LOW_MAX : raw;
      end
      else
      begin
         // Code bits weigh 160/80/40/20/10 mA
         raw = `FCC_HIGH_BASE
             + 9'(ctl.charge_current_code) * `FCC_HIGH_STEP;
         s.current_ma = (raw > `FCC_HIGH_MAX) ? `FCC_HIGH_CLAMP : raw;
      end
      // External path bypasses the clamp entirely
      if (s.use_external)
         s.current_ma = 9'h000;
      return s;
   endfunction : decode_setting

   // ---------------------------------------------------------------
   // Pin synchronisers and bus condition detect
   // ---------------------------------------------------------------
   // Two stages before use; edges are taken from the second stage only
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end
      else
      begin
         scl_sync_reg <= {scl_sync_reg[0], scl_in};
         sda_sync_reg <= {sda_sync_reg[0], sda_in};
         scl_prev_reg <= scl_sync_reg[1];
         sda_prev_reg <= sda_sync_reg[1];
      end
   end

   // Start and stop are sda edges while scl stays high
   assign scl_rise = scl_sync_reg[1] & ~scl_prev_reg;
   assign scl_fall = ~scl_sync_reg[1] & scl_prev_reg;
   assign start_seen = scl_sync_reg[1] & scl_prev_reg
                     & ~sda_sync_reg[1] & sda_prev_reg;
   assign stop_seen = scl_sync_reg[1] & scl_prev_reg
                    & sda_sync_reg[1] & ~sda_prev_reg;

   // Stored byte, not the clamped setting, is what a read returns
   assign read_data = (pointer_reg == `FCC_REG_OFFSET)
                    ? control_reg : `FCC_UNMAPPED_READ;

   // Write lands on the falling edge that follows the eighth data bit
   assign wr_strobe = scl_fall && (state_reg == SER_WDATA) && byte_done_reg
                    && (pointer_reg == `FCC_REG_OFFSET);

   // ---------------------------------------------------------------
   // Serial slave engine
   // ---------------------------------------------------------------
   // Sda changes only on scl falls, so data stays still while scl is high
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         state_reg <= SER_IDLE;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         pointer_reg <= 8'h00;
         bit_cnt_reg <= 3'h0;
         byte_done_reg <= 1'b0;
         rw_reg <= 1'b0;
         nack_reg <= 1'b0;
         sda_oe_out <= 1'b0;
      end
      else if (start_seen)
      begin
         // Repeated start also lands here and keeps the pointer
         state_reg <= SER_ADDR;
         bit_cnt_reg <= 3'h0;
         byte_done_reg <= 1'b0;
         sda_oe_out <= 1'b0;
      end
      else if (stop_seen)
      begin
         state_reg <= SER_IDLE;
         sda_oe_out <= 1'b0;
      end
      else if (scl_rise)
      begin
         case (state_reg)
            SER_ADDR, SER_PTR, SER_WDATA, SER_RDATA:
            begin
               shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
               byte_done_reg <= (bit_cnt_reg == `FCC_LAST_BIT);
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
            SER_RACK: nack_reg <= sda_sync_reg[1];
            default: nack_reg <= nack_reg;
         endcase
      end
      else if (scl_fall)
      begin
         case (state_reg)
            SER_ADDR:
            begin
               if (byte_done_reg)
               begin
                  byte_done_reg <= 1'b0;
                  if (shift_reg[7:1] == DEV_ADDR)
                  begin
                     rw_reg <= shift_reg[0];
                     sda_oe_out <= 1'b1;
                     state_reg <= SER_ADDR_ACK;
                  end
                  else
                     state_reg <= SER_IDLE;
               end
            end
            SER_ADDR_ACK:
            begin
               if (rw_reg)
               begin
                  // First read bit goes out right after the ack
                  sda_oe_out <= ~read_data[7];
                  tx_reg <= {read_data[6:0], 1'b0};
                  state_reg <= SER_RDATA;
               end
               else
               begin
                  sda_oe_out <= 1'b0;
                  state_reg <= SER_PTR;
               end
            end
            SER_PTR:
            begin
               if (byte_done_reg)
               begin
                  byte_done_reg <= 1'b0;
                  pointer_reg <= shift_reg;
                  sda_oe_out <= 1'b1;
                  state_reg <= SER_PTR_ACK;
               end
            end
            SER_WDATA:
            begin
               if (byte_done_reg)
               begin
                  // Unmapped bytes are acked and dropped
                  byte_done_reg <= 1'b0;
                  sda_oe_out <= 1'b1;
                  state_reg <= SER_WDATA_ACK;
               end
            end
            SER_PTR_ACK, SER_WDATA_ACK:
            begin
               if (state_reg == SER_WDATA_ACK)
                  pointer_reg <= pointer_reg + 8'h01;
               sda_oe_out <= 1'b0;
               state_reg <= SER_WDATA;
            end
            SER_RDATA:
            begin
               if (byte_done_reg)
               begin
                  byte_done_reg <= 1'b0;
                  pointer_reg <= pointer_reg + 8'h01; // Ready for an ack
                  sda_oe_out <= 1'b0;
                  state_reg <= SER_RACK;
               end
               else
               begin
                  sda_oe_out <= ~tx_reg[7];
                  tx_reg <= {tx_reg[6:0], 1'b0};
               end
            end
            SER_RACK:
            begin
               // Pointer already moved, so an ack fetches the next byte
               if (nack_reg)
               begin
                  sda_oe_out <= 1'b0;
                  state_reg <= SER_IDLE;
               end
               else
               begin
                  sda_oe_out <= ~read_data[7];
                  tx_reg <= {read_data[6:0], 1'b0};
                  state_reg <= SER_RDATA;
               end
            end
            default: sda_oe_out <= 1'b0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   // All eight bits are plain read/write storage
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         control_reg <= `FCC_REG_RESET;
      else if (wr_strobe)
         control_reg <= shift_reg;
   end

   // ---------------------------------------------------------------
   // Effective setting outputs
   // ---------------------------------------------------------------
   // Registered so the analog side never sees decode glitches
   assign setting_next = decode_setting(control_reg);

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         // Matches decode of the reset byte: high range, code zero
         charge_current_ma_out <= `FCC_HIGH_BASE;
         external_current_select_out <= 1'b0;
         charger_disable_out <= 1'b0;
         high_impedance_out <= 1'b0;
         sda_out <= 1'b0;
      end
      else
      begin
         charge_current_ma_out <= setting_next.current_ma;
         external_current_select_out <= setting_next.use_external;
         charger_disable_out <= setting_next.charger_disable;
         high_impedance_out <= setting_next.high_impedance;
         sda_out <= 1'b0;
      end
   end

endmodule : fast_charge_current_control
`default_nettype wire

// ### fcc_params.svh
// Constants for the fast-charge current control register and its serial port.
// Assumes inclusion by the package and the top module only.
`ifndef FCC_PARAMS_SVH
`define FCC_PARAMS_SVH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define FCC_REG_OFFSET 8'h03
`define FCC_REG_RESET 8'h80
`define FCC_UNMAPPED_READ 8'h00

// ---------------------------------------------------------------
// Current decode, values in mA
// ---------------------------------------------------------------
`define FCC_LOW_BASE 9'h005
`define FCC_LOW_STEP 9'h001
`define FCC_LOW_MAX 9'h023
`define FCC_HIGH_BASE 9'h028
`define FCC_HIGH_STEP 9'h00a
`define FCC_HIGH_MAX 9'h12c
`define FCC_HIGH_CLAMP 9'h0c8
`define FCC_CODE_EXTERNAL 5'h1f

// ---------------------------------------------------------------
// Serial port
// ---------------------------------------------------------------
// Arbitrary value, not tied to any part
`define FCC_DEV_ADDR 7'h2a
`define FCC_LAST_BIT 3'h7

`endif

// ### fcc_pkg.sv
// Types shared by the fast-charge current control block.
// Assumes fcc_params.svh is on the include path.
`default_nettype none
package fcc_pkg;
   `include "fcc_params.svh"

   // Layout of the control byte, bit 7 first
   typedef struct packed {
      logic charge_range_select;
      logic [4:0] charge_current_code;
      logic charger_disable;
      logic high_impedance;
   } fast_charge_control_t;

   // Effective charge setting handed to the analog loop
   typedef struct packed {
      logic [8:0] current_ma;
      logic use_external;
      logic charger_disable;
      logic high_impedance;
   } charge_setting_t;

   typedef enum logic [3:0] {
      SER_IDLE,
      SER_ADDR,
      SER_ADDR_ACK,
      SER_PTR,
      SER_PTR_ACK,
      SER_WDATA,
      SER_WDATA_ACK,
      SER_RDATA,
      SER_RACK
   } serial_state_t;
endpackage : fcc_pkg
`default_nettype wire

// ### fcc_checker.sv
// Port checks for the fast-charge current control block.
// Assumes a bind onto the block; one clock, async low reset.
`timescale 1ns/10ps
`default_nettype none
module fcc_checker
   import fcc_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic [8:0] charge_current_ma_out,
   input wire logic external_current_select_out,
   input wire logic charger_disable_out,
   input wire logic high_impedance_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // Short aliases for the decoded outputs
   wire logic [8:0] ma = charge_current_ma_out;
   wire logic ext = external_current_select_out;
   wire logic [1:0] flg = {charger_disable_out, high_impedance_out};
   // An answer bit must stay driven for eight clocks after sda_oe_out rises
   sequence held_s;
      sda_oe_out [*8];
   endsequence
   // Decode and wire relations
   reset_value_a:
      assert property (!$past(reset_n_in)
         |-> ma == 9'h028 && !ext && flg == 2'h0)
      else $error("bad decode after reset");
   open_drain_a:
      assert property (sda_out == 1'b0) else $error("sda driven high");
   ack_hold_a:
      assert property ($rose(sda_oe_out) |-> held_s)
      else $error("answer short");
   oe_timing_a:
      assert property ($changed(sda_oe_out) |-> !scl_in)
      else $error("oe moved");
   external_zero_a:
      assert property (ext |-> ma == 9'h000) else $error("external not zero");
   low_span_a:
      assert property (!ext && ma < 9'h028 |-> ma >= 9'h005 && ma <= 9'h023)
      else $error("low range out of span");
   high_span_a:
      assert property (ma >= 9'h028 |-> ma <= 9'h12c && ma % 9'h00a == 9'h000)
      else $error("high range off step");
   quiet_update_a:
      assert property ($changed({ma, ext, flg}) |-> !scl_in)
      else $error("outputs moved with clock high");
endmodule : fcc_checker
`default_nettype wire

// ### host_i2c_model.sv
// Host side of the two-wire port, driven through its tasks.
// Assumes a pull-up on sda; scl is driven push-pull, no stretching.
`timescale 1ns/10ps
`default_nettype none
module host_i2c_model
   import fcc_pkg::*;
(
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_low_out
);
   logic lvl = 1'b1;
   logic [6:0] dev_addr = 7'h2a;
   // Released line floats high through the pull-up
   assign sda_low_out = !lvl;
   initial scl_out = 1'b1;
   // Each line change holds ten clocks, past the sync delay
   task automatic step(input logic c, input logic d);
      @(posedge clk_in);
      #1 scl_out = c;
      lvl = d;
      repeat (9) @(posedge clk_in);
   endtask : step
   // Data moves only with scl low, after scl has fallen
   task automatic bit_io(input logic d, output logic q);
      step(1'b0, lvl);
      step(1'b0, d);
      step(1'b1, d);
      q = sda_in;
   endtask : bit_io
   // Start is cond(1,0), stop is cond(0,1)
   task automatic cond(input logic a, input logic b);
      step(1'b0, lvl);
      step(1'b0, a);
      step(1'b1, a);
      step(1'b1, b);
   endtask : cond
   // Eight bits MSB first, then the answer bit
   task automatic xfer(input logic [7:0] d, output logic [7:0] q,
      input logic k, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(k, a);
   endtask : xfer
   task automatic write_reg(input logic [7:0] p, input logic [7:0] d,
      output logic a);
      logic [7:0] x;
      logic a0, a1;
      cond(1'b1, 1'b0);
      xfer({dev_addr, 1'b0}, x, 1'b1, a0);
      xfer(p, x, 1'b1, a1);
      xfer(d, x, 1'b1, a);
      a = a | a0 | a1;
      cond(1'b0, 1'b1);
   endtask : write_reg
   // Pointer write, repeated start, one byte, nack to end
   task automatic read_reg(input logic [7:0] p, output logic [7:0] q,
      output logic a);
      logic [7:0] x;
      logic a0, a1, a2;
      cond(1'b1, 1'b0);
      xfer({dev_addr, 1'b0}, x, 1'b1, a0);
      xfer(p, x, 1'b1, a1);
      cond(1'b1, 1'b0);
      xfer({dev_addr, 1'b1}, x, 1'b1, a2);
      xfer(8'hff, q, 1'b1, a);
      a = a0 | a1 | a2;
      cond(1'b0, 1'b1);
   endtask : read_reg
   // Two bytes from one pointer, ack after the first, nack after the second
   task automatic read_two(input logic [7:0] p, output logic [7:0] q0,
      output logic [7:0] q1, output logic a);
      logic [7:0] x;
      logic a0, a1, a2, a3;
      cond(1'b1, 1'b0);
      xfer({dev_addr, 1'b0}, x, 1'b1, a0);
      xfer(p, x, 1'b1, a1);
      cond(1'b1, 1'b0);
      xfer({dev_addr, 1'b1}, x, 1'b1, a2);
      xfer(8'hff, q0, 1'b0, a3);
      xfer(8'hff, q1, 1'b1, a);
      a = a0 | a1 | a2 | a3;
      cond(1'b0, 1'b1);
   endtask : read_two
endmodule : host_i2c_model
`default_nettype wire

// ### fast_charge_current_control_bench.sv
// Self-checking bench for the fast-charge current control block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module fast_charge_current_control_bench
   import fcc_pkg::*;
;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic scl, host_low, so, oe, ext, dis, hiz;
   logic [8:0] ma;
   wire logic sda = !(oe || host_low);
   int errors = 0;
   int checks_done = 0;
   logic [7:0] vals [19] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20,
      8'h40, 8'h78, 8'h7c, 8'h80, 8'h84, 8'h88, 8'h90,
      8'ha0, 8'hc0, 8'he8, 8'hec, 8'hfc, 8'h02, 8'h01};
   always #20 clk_in = ~clk_in;
   fast_charge_current_control #(.DEV_ADDR(7'h2a))
      i_fast_charge_current_control (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda),
      .sda_out(so), .sda_oe_out(oe), .charge_current_ma_out(ma),
      .external_current_select_out(ext), .charger_disable_out(dis),
      .high_impedance_out(hiz));
   host_i2c_model i_host_i2c_model (.clk_in(clk_in), .sda_in(sda),
      .scl_out(scl), .sda_low_out(host_low));
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Expected current from the range, code and clamp figures
   function automatic logic [8:0] exp_ma(input logic [7:0] b);
      logic [8:0] c;
      logic [8:0] v;
      c = {4'h0, b[6:2]};
      v = b[7] ? 9'h028 + c * 9'h00a : 9'h005 + c;
      if (c == 9'h01f) return 9'h000;
      if (!b[7] && v > 9'h023) return 9'h023;
      if (b[7] && v > 9'h12c) return 9'h0c8;
      return v;
   endfunction : exp_ma
   task automatic outs(input logic [7:0] b);
      check(ma, exp_ma(b));
      check({6'h00, ext, dis, hiz}, {6'h00, &b[6:2], b[1:0]});
   endtask : outs
   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial
   begin
      logic [7:0] q;
      logic [7:0] q2;
      logic a;
      repeat (5) @(posedge clk_in);
      #1 reset_n_in = 1'b1;
      repeat (4) @(posedge clk_in);
      outs(8'h80);
      foreach (vals[i])
      begin
         if (&vals[i][6:2])
            i_host_i2c_model.write_reg(8'h04, 8'h01, a);
         i_host_i2c_model.write_reg(8'h03, vals[i], a);
         check({8'h00, a}, 9'h000);
         outs(vals[i]);
         i_host_i2c_model.read_reg(8'h03, q, a);
         check({a, q}, {1'b0, vals[i]});
      end
      // Unmapped pointer reads as zero
      i_host_i2c_model.read_reg(8'h05, q, a);
      check({a, q}, 9'h000);
      // Continued read runs from an unmapped byte into the register
      i_host_i2c_model.read_two(8'h02, q, q2, a);
      check({a, q}, 9'h000);
      check({1'b0, q2}, 9'h001);
      // Foreign address is ignored, byte stays put
      i_host_i2c_model.dev_addr = 7'h2b;
      i_host_i2c_model.write_reg(8'h03, 8'h55, a);
      check({8'h00, a}, 9'h001);
      i_host_i2c_model.dev_addr = 7'h2a;
      outs(8'h01);
      // Second reset in mid-run restores the default byte
      @(posedge clk_in);
      #1 reset_n_in = 1'b0;
      repeat (2) @(posedge clk_in);
      #1 reset_n_in = 1'b1;
      repeat (4) @(posedge clk_in);
      i_host_i2c_model.read_reg(8'h03, q, a);
      check({a, q}, 9'h080);
      outs(8'h80);
      complete_run();
   end
   // Watchdog well beyond the expected run length
   initial
   begin
      repeat (95000) @(posedge clk_in);
      errors++;
      complete_run();
   end
endmodule : fast_charge_current_control_bench
bind fast_charge_current_control fcc_checker i_fcc_checker (
   .clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
   .charge_current_ma_out(charge_current_ma_out),
   .external_current_select_out(external_current_select_out),
   .charger_disable_out(charger_disable_out),
   .high_impedance_out(high_impedance_out));
`default_nettype wire
